// ### mode_control_pkg.sv
/*
  Constants for the mode control register block of a high-speed USB
  peripheral controller: register offset, field positions, masks, reset
  value, timing figures and the power state encoding.
  Assumes a 25 MHz reference clock and a 16-bit parallel register bus.
*/
// Overview of operation
// - Two-byte mode control register sits at offset 0Ch of the register bus.
// - Bit 9 gates the DMA clock; cleared by power-on and bus reset.
// - Bit 8 reads back the sensed VBUS pin level, read-only.
// - Bit 7 keeps clock running in suspend; otherwise oscillator stops after delay.
// - Bit 6 written one then zero: wait 5 ms, drive resume 10 ms.
// - Bit 5 written one then zero enters suspend; clock follows bit 7.
// - Bit 4 written one then zero performs a soft reset like the pin.
// - Bit 3 is the global interrupt enable, combined with per-source enables.
// - Enable clear blocks the interrupt pin; setting it with pending asserts immediately.
// - Pulsed mode: events before enabling may give no pulse; software polls.
// - Bit 2 set: a read of the mode register in suspend wakes device and restarts clock.
// - Bit 1 clear: suspend pin high while suspended, low otherwise.
// - Bit 1 set: suspend pin low except 1 ms high pulse on wake.
// - Without connect and VBUS, bus activity is ignored; suspend command still obeyed.
// - VBUS off removes DP pull-up; suspend interrupt after debounce latency.
// - Clearing bit 0, software connect, raises no interrupt.
// - In OTG mode the DP pull-up follows VBUS sensing status.
// - Reserved bits ignore writes and read back as zero.
// - Access is over a 16-bit bus.
package mode_control_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] MODE_CONTROL_ADDR = 8'h0C;

  // Field positions.
  localparam int SOFTWARE_CONNECT_BIT = 0;
  localparam int SUSPEND_PIN_PULSE_MODE_BIT = 1;
  localparam int WAKE_ON_CHIP_SELECT_BIT = 2;
  localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 3;
  localparam int SOFT_RESET_TRIGGER_BIT = 4;
  localparam int GO_SUSPEND_BIT = 5;
  localparam int SEND_RESUME_BIT = 6;
  localparam int CLOCK_ALWAYS_ON_BIT = 7;
  localparam int VBUS_PIN_STATUS_BIT = 8;
  localparam int DMA_CLOCK_GATE_BIT = 9;

  localparam logic [DATA_W-1:0] MODE_RESET_VALUE = 16'h0000;
  localparam logic [DATA_W-1:0] MODE_WRITABLE_MASK = 16'h02FF;
  localparam logic [DATA_W-1:0] MODE_BUS_RESET_KEEP_MASK = 16'h0009;

  // Timing figures in their own units.
  localparam int CLK_HZ = 32'h017D_7840;
  localparam int RESUME_WAIT_MS = 32'h0000_0005;
  localparam int RESUME_DRIVE_MS = 32'h0000_000A;
  localparam int CLOCK_OFF_DELAY_MS = 32'h0000_0002;
  localparam int SUSPEND_PULSE_MS = 32'h0000_0001;
  localparam int VBUS_DEBOUNCE_US = 32'h0000_0064;
  localparam int CYCLES_PER_MS = CLK_HZ / 32'h0000_03E8;
  // Divide first: the product of the raw figures would overflow a 32-bit int.
  localparam int VBUS_DEBOUNCE_CYCLES = VBUS_DEBOUNCE_US * (CLK_HZ / 32'h000F_4240);

  localparam int TIMER_W = 20;

  // Timer channel indices.
  localparam int TMR_RESUME_WAIT = 0;
  localparam int TMR_RESUME_DRIVE = 1;
  localparam int TMR_CLOCK_OFF = 2;
  localparam int TMR_SUSPEND_PULSE = 3;
  localparam int TMR_VBUS_DEBOUNCE = 4;
  localparam int TMR_COUNT = 5;

  typedef enum logic [1:0] {
    ST_AWAKE = 2'b00,
    ST_SUSPEND = 2'b01,
    ST_CLOCK_OFF = 2'b10
  } power_state_t;

endpackage

// ### delay_timer.sv
/*
  Down-counting delay timer: loads a cycle count on start, reports busy
  while counting and a one-cycle done on the last counted cycle.
  Assumes start and clear come from logic on the same clock.
*/
`timescale 1ns/10ps
module delay_timer #(
  parameter int WIDTH = 20
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Control
  input wire logic clear_i,
  input wire logic start_i,
  input wire logic [WIDTH-1:0] load_i,
  // Status
  output logic busy_o,
  output logic done_o
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (clear_i) begin
      next_count = '0;
    end else if (start_i) begin
      next_count = load_i;
    end else if (count != '0) begin
      next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy_o = (count != '0);
  assign done_o = (count == WIDTH'(1)) && !clear_i;

endmodule

// ### mode_control.sv
/*
  Mode control register of a high-speed USB peripheral controller and the
  power, resume, soft reset, interrupt gating and pull-up logic it steers.
  Assumes an asynchronous 16-bit parallel register bus on pins, a VBUS pin,
  and same-clock inputs from the serial engine and interrupt logic.
*/
`timescale 1ns/10ps
module mode_control
  import mode_control_pkg::*;
#(
  parameter int RESUME_WAIT_CYCLES = RESUME_WAIT_MS * CYCLES_PER_MS,
  parameter int RESUME_DRIVE_CYCLES = RESUME_DRIVE_MS * CYCLES_PER_MS,
  parameter int CLOCK_OFF_CYCLES = CLOCK_OFF_DELAY_MS * CYCLES_PER_MS,
  parameter int SUSPEND_PULSE_CYCLES = SUSPEND_PULSE_MS * CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Parallel register bus pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_n_o,
  // USB side pins and engine status
  input wire logic vbus_i,
  input wire logic usb_bus_reset_i,
  input wire logic usb_resume_i,
  input wire logic otg_mode_i,
  // Interrupt sources
  input wire logic int_pending_i,
  input wire logic int_event_i,
  input wire logic int_pulse_mode_i,
  // Controls to the rest of the chip
  output logic int_o,
  output logic dma_clock_en_o,
  output logic osc_enable_o,
  output logic suspend_o,
  output logic resume_drive_o,
  output logic soft_reset_o,
  output logic dp_pullup_o,
  output logic usb_traffic_qualified_o,
  output logic suspend_irq_o
);

  localparam int SYNC_W = 4 + ADDR_W + DATA_W;

  // Pin synchroniser; the first stage feeds only the second.
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic [SYNC_W-1:0] next_sync_meta;
  logic [SYNC_W-1:0] next_sync_q;

  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic vbus_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;

  // Bus access tracking.
  logic wr_active;
  logic rd_active;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic next_wr_active;
  logic next_rd_active;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [DATA_W-1:0] next_wr_data;

  // Register state.
  logic [DATA_W-1:0] ctrl;
  logic [DATA_W-1:0] next_ctrl;
  power_state_t state;
  power_state_t next_state;
  logic vbus_prev;
  logic next_vbus_prev;
  logic [DATA_W-1:0] next_data;
  logic int_pulse;
  logic next_int_pulse;
  logic soft_reset;
  logic next_soft_reset;
  logic suspend_irq;
  logic next_suspend_irq;

  // Decoded events.
  logic wr_now;
  logic rd_now;
  logic write_commit;
  logic read_start;
  logic ev_resume;
  logic ev_suspend;
  logic ev_soft_reset;
  logic wake;
  logic suspended;

  // Timers.
  logic [TMR_COUNT-1:0] tmr_start;
  logic [TMR_COUNT-1:0] tmr_clear;
  logic [TMR_COUNT-1:0] tmr_busy;
  logic [TMR_COUNT-1:0] tmr_done;
  logic [TIMER_W-1:0] tmr_load [TMR_COUNT];

  assign {cs_n_s, rd_n_s, wr_n_s, vbus_s, addr_s, data_s} = sync_q;

  always_comb begin
    next_sync_meta = {cs_n_i, rd_n_i, wr_n_i, vbus_i, addr_i, data_i};
    next_sync_q = sync_meta;
  end

  // Writes commit when the strobe ends, using the address and data held
  // during the last active cycle, so that hold time at the pins is not
  // needed past the strobe.
  always_comb begin
    wr_now = !cs_n_s && !wr_n_s;
    rd_now = !cs_n_s && !rd_n_s && (addr_s == MODE_CONTROL_ADDR);
    next_wr_active = wr_now;
    next_rd_active = rd_now;
    next_wr_addr = wr_now ? addr_s : wr_addr;
    next_wr_data = wr_now ? data_s : wr_data;
    write_commit = wr_active && !wr_now && (wr_addr == MODE_CONTROL_ADDR);
    read_start = rd_now && !rd_active;
  end

  // A command bit fires when it holds one and is then written zero.
  always_comb begin
    ev_resume = write_commit && ctrl[SEND_RESUME_BIT] && !wr_data[SEND_RESUME_BIT];
    ev_suspend = write_commit && ctrl[GO_SUSPEND_BIT] && !wr_data[GO_SUSPEND_BIT];
    ev_soft_reset = write_commit && ctrl[SOFT_RESET_TRIGGER_BIT]
                    && !wr_data[SOFT_RESET_TRIGGER_BIT];
  end

  // Soft reset beats a write and a bus reset in the same cycle. It leaves the
  // pin synchroniser alone, so a bus access in flight still ends cleanly.
  always_comb begin
    next_ctrl = ctrl;
    if (write_commit) begin
      next_ctrl = wr_data & MODE_WRITABLE_MASK;
    end
    if (usb_bus_reset_i) begin
      next_ctrl = next_ctrl & MODE_BUS_RESET_KEEP_MASK;
    end
    if (ev_soft_reset) begin
      next_ctrl = MODE_RESET_VALUE;
    end
    next_soft_reset = ev_soft_reset;
  end

  // Power state: suspend is obeyed whatever the connect and VBUS state.
  always_comb begin
    suspended = (state != ST_AWAKE);
    wake = suspended && ((read_start && ctrl[WAKE_ON_CHIP_SELECT_BIT])
                         || usb_resume_i || ev_resume);
    next_state = state;
    case (state)
      ST_AWAKE: begin
        if (ev_suspend) begin
          next_state = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (wake) begin
          next_state = ST_AWAKE;
        end else if (tmr_done[TMR_CLOCK_OFF] && !ctrl[CLOCK_ALWAYS_ON_BIT]) begin
          next_state = ST_CLOCK_OFF;
        end
      end
      ST_CLOCK_OFF: begin
        if (wake) begin
          next_state = ST_AWAKE;
        end
      end
      default: begin
        next_state = ST_AWAKE;
      end
    endcase
    if (ev_soft_reset) begin
      next_state = ST_AWAKE;
    end
  end

  // Timer scheduling.
  always_comb begin
    tmr_load[TMR_RESUME_WAIT] = TIMER_W'(RESUME_WAIT_CYCLES);
    tmr_load[TMR_RESUME_DRIVE] = TIMER_W'(RESUME_DRIVE_CYCLES);
    tmr_load[TMR_CLOCK_OFF] = TIMER_W'(CLOCK_OFF_CYCLES);
    tmr_load[TMR_SUSPEND_PULSE] = TIMER_W'(SUSPEND_PULSE_CYCLES);
    tmr_load[TMR_VBUS_DEBOUNCE] = TIMER_W'(VBUS_DEBOUNCE_CYCLES);
    tmr_start = '0;
    tmr_clear = '0;
    tmr_start[TMR_RESUME_WAIT] = ev_resume;
    tmr_start[TMR_RESUME_DRIVE] = tmr_done[TMR_RESUME_WAIT];
    tmr_start[TMR_CLOCK_OFF] = ev_suspend && !ctrl[CLOCK_ALWAYS_ON_BIT];
    tmr_clear[TMR_CLOCK_OFF] = wake;
    tmr_start[TMR_SUSPEND_PULSE] = wake;
    tmr_start[TMR_VBUS_DEBOUNCE] = vbus_prev && !vbus_s;
    tmr_clear[TMR_VBUS_DEBOUNCE] = vbus_s;
    if (ev_soft_reset) begin
      tmr_start = '0;
      tmr_clear = '1;
    end
  end

  // One down-counter per timed event. A shared width keeps the loop uniform
  // at the cost of a few unused flip-flops on the short timers.
  genvar t;
  generate
    for (t = 0; t < TMR_COUNT; t++) begin : g_timer
      delay_timer #(
        .WIDTH(TIMER_W)
      ) u_timer (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(tmr_clear[t]),
        .start_i(tmr_start[t]),
        .load_i(tmr_load[t]),
        .busy_o(tmr_busy[t]),
        .done_o(tmr_done[t])
      );
    end
  endgenerate

  // VBUS edge detection. A rise of VBUS clears a running debounce, so a
  // short dip never raises the suspend interrupt.
  always_comb begin
    next_vbus_prev = vbus_s;
    next_suspend_irq = tmr_done[TMR_VBUS_DEBOUNCE] && !vbus_s;
  end

  // Interrupt pulse for the pulsed output mode.
  always_comb begin
    // Events that arrive while the enable is clear are dropped in pulsed
    // mode; software has to poll for them after enabling.
    next_int_pulse = int_event_i && ctrl[GLOBAL_INTERRUPT_ENABLE_BIT];
  end

  // Read data; zero whenever no read of the mode register is under way.
  always_comb begin
    next_data = '0;
    if (rd_now) begin
      next_data = ctrl & MODE_WRITABLE_MASK;
      next_data[VBUS_PIN_STATUS_BIT] = vbus_s;
    end
  end

  // The synchroniser resets to idle pins, so that no access is seen while
  // the first stage fills after reset.
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_meta <= '1;
      sync_q <= '1;
    end else begin
      sync_meta <= next_sync_meta;
      sync_q <= next_sync_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_active <= 1'b0;
      rd_active <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
    end else begin
      wr_active <= next_wr_active;
      rd_active <= next_rd_active;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl <= MODE_RESET_VALUE;
      soft_reset <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      soft_reset <= next_soft_reset;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vbus_prev <= 1'b0;
      suspend_irq <= 1'b0;
    end else begin
      vbus_prev <= next_vbus_prev;
      suspend_irq <= next_suspend_irq;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      int_pulse <= 1'b0;
    end else begin
      int_pulse <= next_int_pulse;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_o <= '0;
    end else begin
      data_o <= next_data;
    end
  end

  // The pull-up tracks the synchronised VBUS, so it lags the pin by the
  // two synchroniser cycles rather than a few nanoseconds.
  always_comb begin
    if (otg_mode_i) begin
      dp_pullup_o = vbus_s;
    end else begin
      dp_pullup_o = ctrl[SOFTWARE_CONNECT_BIT] && vbus_s;
    end
    usb_traffic_qualified_o = otg_mode_i || ctrl[SOFTWARE_CONNECT_BIT] || vbus_s;
    if (int_pulse_mode_i) begin
      int_o = int_pulse;
    end else begin
      int_o = int_pending_i && ctrl[GLOBAL_INTERRUPT_ENABLE_BIT];
    end
    if (ctrl[SUSPEND_PIN_PULSE_MODE_BIT]) begin
      suspend_o = tmr_busy[TMR_SUSPEND_PULSE];
    end else begin
      suspend_o = suspended;
    end
  end

  assign data_oe_n_o = !rd_active;
  assign dma_clock_en_o = ctrl[DMA_CLOCK_GATE_BIT];
  assign osc_enable_o = (state != ST_CLOCK_OFF);
  assign resume_drive_o = tmr_busy[TMR_RESUME_DRIVE];
  assign soft_reset_o = soft_reset;
  assign suspend_irq_o = suspend_irq;

endmodule

// ### mode_control_sva.sv
/* Port assertions for the mode control block.
   Assumes a bind to mode_control with its resume drive length. */
`timescale 1ns/10ps
module mode_control_sva
  import mode_control_pkg::*;
#(
  parameter int RESUME_DRIVE_CYCLES = 40
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic vbus_i,
  input wire logic otg_mode_i,
  input wire logic int_pending_i,
  input wire logic int_pulse_mode_i,
  input wire logic [DATA_W-1:0] data_o,
  input wire logic data_oe_n_o,
  input wire logic int_o,
  input wire logic dma_clock_en_o,
  input wire logic resume_drive_o,
  input wire logic soft_reset_o,
  input wire logic dp_pullup_o,
  input wire logic usb_traffic_qualified_o,
  input wire logic suspend_irq_o
);
  localparam int DRIVE_LAST = RESUME_DRIVE_CYCLES - 1;
  logic rd_hit;
  logic [11:0] low_cnt, next_low_cnt;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  assign rd_hit = !cs_n_i && !rd_n_i && addr_i == MODE_CONTROL_ADDR;
  // Saturates so a long VBUS-off stretch cannot wrap below the debounce.
  always_comb begin
    next_low_cnt = low_cnt;
    if (vbus_i) next_low_cnt = 12'h000;
    else if (low_cnt != 12'hFFF) next_low_cnt = low_cnt + 12'h001;
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) low_cnt <= 12'h000;
    else low_cnt <= next_low_cnt;
  end
  a_read_addr: assert property ($fell(data_oe_n_o) |-> $past(rd_hit, 3))
    else $error("data driven without a read of the mode register");
  a_dma_readback: assert property (!data_oe_n_o |-> data_o[9] == dma_clock_en_o)
    else $error("dma gate bit and output disagree");
  a_reserved_zero: assert property (!data_oe_n_o |-> data_o[15:10] == 6'h00)
    else $error("reserved bits not zero");
  a_idle_data_zero: assert property (data_oe_n_o |-> data_o == 16'h0000)
    else $error("read data not zero while idle");
  a_level_gate: assert property (!int_pulse_mode_i && !int_pending_i |-> !int_o)
    else $error("interrupt without pending source");
  a_reset_single: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse too long");
  a_resume_width: assert property ($rose(resume_drive_o) |->
    ##DRIVE_LAST resume_drive_o ##1 !resume_drive_o)
    else $error("resume drive length wrong");
  a_pullup_drop: assert property (!vbus_i [*4] |-> !dp_pullup_o)
    else $error("pull-up kept without VBUS");
  a_otg_qualify: assert property (otg_mode_i |-> usb_traffic_qualified_o)
    else $error("traffic not qualified in OTG mode");
  a_irq_debounce: assert property (suspend_irq_o |->
    (low_cnt >= 12'h9C4) ##1 !suspend_irq_o)
    else $error("suspend interrupt before debounce or too long");
endmodule

// ### host_bus_model.sv
/* Host processor model on the parallel register bus.
   Assumes the testbench calls its tasks and supplies the clock. */
`timescale 1ns/10ps
module host_bus_model
  import mode_control_pkg::*;
(
  input wire logic ref_clk_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] data_o,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic data_oe_n_i
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 8'h00;
    data_o = 16'h0000;
  end
  // Released lines show the inverse so stale values cannot pass.
  task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    addr_o <= a;
    data_o <= d;
    repeat (3) @(posedge ref_clk_i);
    cs_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    addr_o <= ~a;
    data_o <= ~d;
    repeat (5) @(posedge ref_clk_i);
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [15:0] d, output logic oe_n);
    @(posedge ref_clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    addr_o <= a;
    repeat (5) @(posedge ref_clk_i);
    d = data_i;
    oe_n = data_oe_n_i;
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    addr_o <= ~a;
    // Idle gap lets a restarted clock settle before any write.
    repeat (5) @(posedge ref_clk_i);
  endtask
endmodule

// ### testbench.sv
/* Self-checking bench for mode_control with shortened timer counts.
   Assumes host_bus_model and mode_control_sva compiled first. */
`timescale 1ns/10ps
module testbench;
  import mode_control_pkg::*;
  logic ref_clk_i = 1'b0, reset_n_i = 1'b0, vbus_i = 1'b1;
  logic usb_bus_reset_i = 1'b0, usb_resume_i = 1'b0, otg_mode_i = 1'b0;
  logic int_pending_i = 1'b0, int_event_i = 1'b0, int_pulse_mode_i = 1'b0;
  logic cs_n_i, rd_n_i, wr_n_i, data_oe_n_o, int_o, dma_clock_en_o, osc_enable_o;
  logic suspend_o, resume_drive_o, soft_reset_o, dp_pullup_o, qual_o, suspend_irq_o;
  logic [7:0] addr_i;
  logic [15:0] data_i, data_o;
  logic [7:0] mon;
  int n_mismatch = 0, n_compared = 0, n_srst = 0, n_irq = 0, n;
  initial forever #20 ref_clk_i = ~ref_clk_i;
  assign mon = {suspend_irq_o, int_o, osc_enable_o, suspend_o, resume_drive_o, 3'b000};
  always @(posedge ref_clk_i) begin
    n_srst += int'(soft_reset_o === 1'b1);
    n_irq += int'(suspend_irq_o === 1'b1);
  end
  mode_control #(.RESUME_WAIT_CYCLES(20), .RESUME_DRIVE_CYCLES(40), .CLOCK_OFF_CYCLES(10),
    .SUSPEND_PULSE_CYCLES(8)) mode_control_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .addr_i(addr_i), .data_i(data_i),
    .data_o(data_o), .data_oe_n_o(data_oe_n_o), .vbus_i(vbus_i),
    .usb_bus_reset_i(usb_bus_reset_i), .usb_resume_i(usb_resume_i), .otg_mode_i(otg_mode_i),
    .int_pending_i(int_pending_i), .int_event_i(int_event_i),
    .int_pulse_mode_i(int_pulse_mode_i), .int_o(int_o), .dma_clock_en_o(dma_clock_en_o),
    .osc_enable_o(osc_enable_o), .suspend_o(suspend_o), .resume_drive_o(resume_drive_o),
    .soft_reset_o(soft_reset_o), .dp_pullup_o(dp_pullup_o),
    .usb_traffic_qualified_o(qual_o), .suspend_irq_o(suspend_irq_o));
  host_bus_model host_bus_model_i (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n_i), .rd_n_o(rd_n_i),
    .wr_n_o(wr_n_i), .addr_o(addr_i), .data_o(data_i), .data_i(data_o),
    .data_oe_n_i(data_oe_n_o));
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_bus_model_i.bus_write(a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic oe_n;
    host_bus_model_i.bus_read(a, d, oe_n);
    chk("read data", d, e);
    chk("read enable", 16'(oe_n), 16'(a != MODE_CONTROL_ADDR));
  endtask
  task automatic wait_bit(input int b, input logic v, input int lim);
    n = 0;
    while (mon[b] !== v) begin
      @(negedge ref_clk_i);
      n++;
      if (n > lim) begin
        chk("wait", 16'(b), 16'hFFFF);
        final_report();
      end
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(negedge ref_clk_i);
    chk("dma", 16'(dma_clock_en_o), 16'h0000);
    chk("osc", 16'(osc_enable_o), 16'h0001);
    rchk(MODE_CONTROL_ADDR, 16'h0100);
    wr(8'h0C, 16'hFE8B);
    rchk(8'h0C, 16'h038B);
    chk("dma", 16'(dma_clock_en_o), 16'h0001);
    chk("pullup", 16'(dp_pullup_o), 16'h0001);
    int_pending_i <= 1'b1;
    @(negedge ref_clk_i);
    chk("int", 16'(int_o), 16'h0001);
    wr(8'h0C, 16'h0283);
    chk("int", 16'(int_o), 16'h0000);
    wr(8'h0C, 16'h028B);
    chk("int", 16'(int_o), 16'h0001);
    int_pending_i <= 1'b0;
    wr(8'h10, 16'h0000);
    rchk(8'h10, 16'h0000);
    rchk(8'h0C, 16'h038B);
    vbus_i <= 1'b0;
    @(negedge ref_clk_i);
    repeat (4) @(negedge ref_clk_i);
    chk("pullup", 16'(dp_pullup_o), 16'h0000);
    rchk(8'h0C, 16'h028B);
    wait_bit(7, 1'b1, 3000);
    chk("debounce", 16'(n > 2400), 16'h0001);
    @(posedge ref_clk_i);
    vbus_i <= 1'b1;
    usb_bus_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    usb_bus_reset_i <= 1'b0;
    rchk(8'h0C, 16'h0109);
    chk("dma", 16'(dma_clock_en_o), 16'h0000);
    int_pulse_mode_i <= 1'b1;
    int_event_i <= 1'b1;
    @(posedge ref_clk_i);
    int_event_i <= 1'b0;
    wait_bit(6, 1'b1, 4);
    @(posedge ref_clk_i);
    int_pulse_mode_i <= 1'b0;
    wr(8'h0C, 16'h0049);
    wr(8'h0C, 16'h0009);
    wait_bit(3, 1'b1, 40);
    wait_bit(3, 1'b0, 60);
    chk("resume width", 16'(n), 16'd40);
    wr(8'h0C, 16'h002D);
    wr(8'h0C, 16'h000D);
    chk("suspend", 16'(suspend_o), 16'h0001);
    wait_bit(5, 1'b0, 20);
    rchk(8'h0C, 16'h010D);
    chk("suspend", 16'(suspend_o), 16'h0000);
    chk("osc", 16'(osc_enable_o), 16'h0001);
    wr(8'h0C, 16'h00AF);
    wr(8'h0C, 16'h008F);
    repeat (20) @(negedge ref_clk_i);
    chk("suspend", 16'(suspend_o), 16'h0000);
    chk("osc", 16'(osc_enable_o), 16'h0001);
    fork
      rchk(8'h0C, 16'h018F);
      begin
        wait_bit(4, 1'b1, 8);
        wait_bit(4, 1'b0, 20);
        chk("wake pulse", 16'(n), 16'd8);
      end
    join
    wr(8'h0C, 16'h0021);
    wr(8'h0C, 16'h0001);
    chk("suspend", 16'(suspend_o), 16'h0001);
    wait_bit(5, 1'b0, 80);
    @(posedge ref_clk_i);
    usb_resume_i <= 1'b1;
    @(posedge ref_clk_i);
    usb_resume_i <= 1'b0;
    wait_bit(5, 1'b1, 4);
    chk("suspend", 16'(suspend_o), 16'h0000);
    wr(8'h0C, 16'h0210);
    wr(8'h0C, 16'h0200);
    chk("soft resets", 16'(n_srst), 16'd1);
    rchk(8'h0C, 16'h0100);
    wr(8'h0C, 16'h0001);
    wr(8'h0C, 16'h0000);
    chk("irq count", 16'(n_irq), 16'd1);
    otg_mode_i <= 1'b1;
    vbus_i <= 1'b0;
    repeat (5) @(negedge ref_clk_i);
    chk("qualified", 16'(qual_o), 16'h0001);
    chk("pullup", 16'(dp_pullup_o), 16'h0000);
    @(posedge ref_clk_i);
    otg_mode_i <= 1'b0;
    vbus_i <= 1'b1;
    final_report();
  end
endmodule
bind mode_control mode_control_sva #(.RESUME_DRIVE_CYCLES(RESUME_DRIVE_CYCLES)) sva_i (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
  .addr_i(addr_i), .vbus_i(vbus_i), .otg_mode_i(otg_mode_i), .int_pending_i(int_pending_i),
  .int_pulse_mode_i(int_pulse_mode_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
  .int_o(int_o), .dma_clock_en_o(dma_clock_en_o), .resume_drive_o(resume_drive_o),
  .soft_reset_o(soft_reset_o), .dp_pullup_o(dp_pullup_o),
  .usb_traffic_qualified_o(usb_traffic_qualified_o), .suspend_irq_o(suspend_irq_o));
